// ### logic/flp_arbiter.sv
// Purpose: Picks the highest-level pending source in polling order
// Assumes: Pending bits already gated by enables
// Notes: Purely combinational
`timescale 1ns/1ps
module flp_arbiter (
  // Arbitration view
  flp_arb_if.arb arb
);
  import flp_pkg::*;

  flp_lvl_t lvl [NUM_SRC];
  logic [NUM_SRC-1:0] at_lvl;
  flp_lvl_t top_lvl;
  flp_lvl_t busy_lvl;
  logic any_busy;
  logic any_pend;
  logic found;
  flp_src_t pick;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_lvl
      assign lvl[gi] = {arb.prio_high[gi], arb.prio_low[gi]};
    end
  endgenerate

  always_comb begin
    top_lvl = 2'h0;
    any_pend = |arb.src_pend;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (arb.src_pend[i] && lvl[i] > top_lvl) begin
        top_lvl = lvl[i];
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      at_lvl[i] = arb.src_pend[i] && (lvl[i] == top_lvl);
    end
    // Later order entries are overwritten by earlier ones
    found = 1'b0;
    pick = SRC_EXT0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (at_lvl[POLL_ORDER[k]]) begin
        found = 1'b1;
        pick = POLL_ORDER[k];
      end
    end
    any_busy = |arb.svc_busy;
    busy_lvl = 2'h0;
    for (int j = 0; j < NUM_LVL; j++) begin
      if (arb.svc_busy[j]) begin
        busy_lvl = flp_lvl_t'(j);
      end
    end
  end

  // Equal or lower level waits, higher level pre-empts
  assign arb.win_valid = any_pend && found && (!any_busy || top_lvl > busy_lvl);
  assign arb.win_src = pick;
  assign arb.win_level = top_lvl;
endmodule

// ### logic/flp_in_service.sv
// Purpose: Tracks which priority levels have a routine in service
// Assumes: Return pulse always belongs to the highest busy level
// Notes: A take and a return in one cycle both apply
`timescale 1ns/1ps
module flp_in_service (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Service view
  flp_arb_if.svc svc
);
  import flp_pkg::*;

  logic [NUM_LVL-1:0] busy_reg;
  logic [NUM_LVL-1:0] busy_next;
  logic [NUM_LVL-1:0] top_mask;

  always_comb begin
    top_mask = '0;
    for (int j = 0; j < NUM_LVL; j++) begin
      if (busy_reg[j]) begin
        top_mask = NUM_LVL'(1) << j;
      end
    end
    busy_next = busy_reg;
    if (svc.ret) begin
      busy_next = busy_next & ~top_mask;
    end
    if (svc.take) begin
      busy_next[svc.take_level] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      busy_reg <= '0;
    end else begin
      busy_reg <= busy_next;
    end
  end

  assign svc.svc_busy = busy_reg;
endmodule

// ### logic/flp_irq_priority.sv
// Purpose: Top of the four-level nested interrupt priority block
// Assumes: Core pulses vector_ack when it fetches the vector, core_return on exit
// Notes: External pins are active low and pass a two-flop synchroniser
`timescale 1ns/1ps
module flp_irq_priority (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External pins, active low
  input wire logic ext_irq_0_n,
  input wire logic ext_irq_1_n,
  // Peripheral flags
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  input wire logic receive_done_flag,
  input wire logic transmit_done_flag,
  input wire logic two_wire_serial_src,
  input wire logic counter_overflow_flag,
  input wire logic [4:0] module_match_flags,
  // Hardware flag clears
  output logic timer0_flag_clear,
  output logic timer1_flag_clear,
  // Core vectoring
  output logic core_irq_req,
  output logic [7:0] core_vector,
  input wire logic core_vector_ack,
  input wire logic core_return,
  // Event interrupt
  output logic irq_out
);
  import flp_pkg::*;

  flp_arb_if bus_if ();

  flp_arbiter u_arb (
    .arb(bus_if.arb)
  );

  flp_in_service u_svc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .svc(bus_if.svc)
  );

  // Registers
  logic [7:0] priority_high_reg, priority_high_next;
  logic [7:0] priority_low_reg, priority_low_next;
  logic [7:0] irq_enable_reg, irq_enable_next;
  logic [7:0] irq_enable_reg_second, irq_enable_second_next;
  logic [7:0] ext_mode_reg, ext_mode_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;

  // Pin synchronisers and request flags
  logic [1:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [1:0] ext_flag_reg, ext_flag_next;
  logic req_reg, req_next;
  flp_src_t src_reg, src_next;
  flp_lvl_t lvl_reg, lvl_next;
  logic [7:0] vec_reg, vec_next;
  logic clr0_reg, clr0_next;
  logic clr1_reg, clr1_next;

  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] en_bits;
  logic take;
  logic [7:0] events;

  // Gated source requests
  always_comb begin
    raw_req[SRC_EXT0] = ext_flag_reg[0];
    raw_req[SRC_TMR0] = timer0_overflow_flag;
    raw_req[SRC_EXT1] = ext_flag_reg[1];
    raw_req[SRC_TMR1] = timer1_overflow_flag;
    raw_req[SRC_SER] = receive_done_flag | transmit_done_flag;
    raw_req[SRC_TWI] = two_wire_serial_src;
    raw_req[SRC_PCA] = counter_overflow_flag | (|module_match_flags);
    raw_req[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
    en_bits = {irq_enable_reg_second[EN2_TMR2_BIT], irq_enable_reg[6:0]};
  end

  assign bus_if.src_pend = raw_req & en_bits & {NUM_SRC{irq_enable_reg[EN_GLOBAL_BIT]}};
  assign bus_if.prio_high = priority_high_reg;
  assign bus_if.prio_low = priority_low_reg;

  // Take the offered vector; request is one cycle behind arbitration
  assign take = core_vector_ack && req_reg;
  assign bus_if.take = take;
  assign bus_if.take_level = lvl_reg;
  assign bus_if.ret = core_return;

  // External request flags
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (ext_mode_reg[i]) begin
        // Edge mode: falling edge sets, vectoring clears, set wins
        ext_flag_next[i] = ext_flag_reg[i];
        if (take && src_reg == (i == 0 ? SRC_EXT0 : SRC_EXT1)) begin
          ext_flag_next[i] = 1'b0;
        end
        if (ext_s3_reg[i] && !ext_s2_reg[i]) begin
          ext_flag_next[i] = 1'b1;
        end
      end else begin
        // Level mode follows the pin, never cleared by hardware
        ext_flag_next[i] = !ext_s2_reg[i];
      end
    end
  end

  // Vector offer to the core
  always_comb begin
    req_next = bus_if.win_valid && !take;
    src_next = bus_if.win_src;
    lvl_next = bus_if.win_level;
    vec_next = VECTOR[bus_if.win_src];
    clr0_next = take && (src_reg == SRC_TMR0);
    clr1_next = take && (src_reg == SRC_TMR1);
  end

  // Sticky events: taken, pre-empted, returned
  always_comb begin
    events = '0;
    events[ST_TAKEN_BIT] = take;
    events[ST_PREEMPT_BIT] = take && (|bus_if.svc_busy);
    events[ST_RETURN_BIT] = core_return;
  end

  // Register writes; hardware set wins over write-one-to-clear
  always_comb begin
    priority_high_next = priority_high_reg;
    priority_low_next = priority_low_reg;
    irq_enable_next = irq_enable_reg;
    irq_enable_second_next = irq_enable_reg_second;
    ext_mode_next = ext_mode_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PRIO_HIGH: priority_high_next = reg_wdata;
        ADDR_PRIO_LOW: priority_low_next = reg_wdata;
        ADDR_ENABLE: irq_enable_next = reg_wdata;
        ADDR_ENABLE_2: irq_enable_second_next = reg_wdata & 8'h01;
        ADDR_EXT_MODE: ext_mode_next = reg_wdata & 8'h03;
        ADDR_IRQ_MASK: mask_next = reg_wdata & 8'h07;
        ADDR_IRQ_STAT: stat_next = stat_reg & ~reg_wdata;
        default: ;
      endcase
    end
    stat_next = stat_next | events;
  end

  // Read data, one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PRIO_HIGH: rdata_next = priority_high_reg;
        ADDR_PRIO_LOW: rdata_next = priority_low_reg;
        ADDR_ENABLE: rdata_next = irq_enable_reg;
        ADDR_ENABLE_2: rdata_next = irq_enable_reg_second;
        ADDR_EXT_MODE: rdata_next = ext_mode_reg;
        ADDR_IRQ_STAT: rdata_next = stat_reg;
        ADDR_IRQ_MASK: rdata_next = mask_reg;
        ADDR_IN_SERVICE: rdata_next = {4'h0, bus_if.svc_busy};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Software-visible registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      priority_high_reg <= RST_REG;
      priority_low_reg <= RST_REG;
      irq_enable_reg <= RST_REG;
      irq_enable_reg_second <= RST_REG;
      ext_mode_reg <= RST_REG;
      stat_reg <= RST_REG;
      mask_reg <= RST_REG;
    end else begin
      priority_high_reg <= priority_high_next;
      priority_low_reg <= priority_low_next;
      irq_enable_reg <= irq_enable_next;
      irq_enable_reg_second <= irq_enable_second_next;
      ext_mode_reg <= ext_mode_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= RST_REG;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Pins reset to their idle high level so no false edge follows reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_s1_reg <= 2'h3;
      ext_s2_reg <= 2'h3;
      ext_s3_reg <= 2'h3;
    end else begin
      ext_s1_reg <= {ext_irq_1_n, ext_irq_0_n};
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // External request flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_flag_reg <= 2'h0;
    end else begin
      ext_flag_reg <= ext_flag_next;
    end
  end

  // Vector offer and flag clear pulses; one cycle of latency buys a clean registered vector
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_reg <= 1'b0;
      src_reg <= SRC_EXT0;
      lvl_reg <= 2'h0;
      vec_reg <= 8'h00;
      clr0_reg <= 1'b0;
      clr1_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      src_reg <= src_next;
      lvl_reg <= lvl_next;
      vec_reg <= vec_next;
      clr0_reg <= clr0_next;
      clr1_reg <= clr1_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign core_irq_req = req_reg;
  assign core_vector = vec_reg;
  assign timer0_flag_clear = clr0_reg;
  assign timer1_flag_clear = clr1_reg;
  assign irq_out = |(stat_reg & mask_reg);
endmodule

// ### pkg/flp_arb_if.sv
// Purpose: Carries requests, levels, winner and in-service state between modules
// Assumes: All signals on ref_clk
// Notes: ctl is the top module's view
`timescale 1ns/1ps
interface flp_arb_if;
  import flp_pkg::*;
  logic [NUM_SRC-1:0] src_pend;
  logic [NUM_SRC-1:0] prio_high;
  logic [NUM_SRC-1:0] prio_low;
  logic [NUM_LVL-1:0] svc_busy;
  logic win_valid;
  flp_src_t win_src;
  flp_lvl_t win_level;
  logic take;
  flp_lvl_t take_level;
  logic ret;
  modport arb(input src_pend, prio_high, prio_low, svc_busy,
              output win_valid, win_src, win_level);
  modport svc(input take, take_level, ret, output svc_busy);
  modport ctl(output src_pend, prio_high, prio_low, take, take_level, ret,
              input svc_busy, win_valid, win_src, win_level);
endinterface

// ### pkg/flp_pkg.sv
// Purpose: Constants for the four-level nested interrupt priority block
// Assumes: 8-bit register port, one clock, synchronous reset
// Notes: Source index equals the bit position in the priority registers
//
// Summary of operation
// - Eight sources, four levels, nested service
// - Level is {high bit, low bit}
// - Priority-high register sits at B7H
// - Take only above every in-service level
// - Equal or lower request waits until return
// - Higher request pre-empts lower routine immediately
// - Per-level in-service tracking resumes interrupted routine
// - Fixed polling order within one level
// - Fixed vector address per source
// - Clear timer 0, timer 1 and edge external flags
// - Multi-flag sources are ORed together
// - External flag hardware clear only when edge
// - Global enable gates all individual enables
package flp_pkg;
  localparam int NUM_SRC = 8;
  localparam int NUM_LVL = 4;
  typedef logic [2:0] flp_src_t;
  typedef logic [1:0] flp_lvl_t;

  // Source index, equal to bit position in priority registers and, SRC_TMR2 aside, in the enable register
  localparam flp_src_t SRC_EXT0 = 3'h0;
  localparam flp_src_t SRC_TMR0 = 3'h1;
  localparam flp_src_t SRC_EXT1 = 3'h2;
  localparam flp_src_t SRC_TMR1 = 3'h3;
  localparam flp_src_t SRC_SER = 3'h4;
  localparam flp_src_t SRC_TWI = 3'h5;
  localparam flp_src_t SRC_PCA = 3'h6;
  localparam flp_src_t SRC_TMR2 = 3'h7;

  // Polling order, first entry wins a tie
  localparam flp_src_t POLL_ORDER [NUM_SRC] = '{SRC_EXT0, SRC_TWI, SRC_TMR0, SRC_EXT1,
                                                SRC_TMR1, SRC_SER, SRC_TMR2, SRC_PCA};
  // Vector address indexed by source
  localparam logic [7:0] VECTOR [NUM_SRC] = '{8'h03, 8'h0B, 8'h13, 8'h1B,
                                             8'h23, 8'h2B, 8'h33, 8'h3B};

  // Register offsets
  localparam logic [7:0] ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PRIO_HIGH = 8'hB7;
  localparam logic [7:0] ADDR_PRIO_LOW = 8'hB8;
  localparam logic [7:0] ADDR_ENABLE_2 = 8'hE8;
  localparam logic [7:0] ADDR_EXT_MODE = 8'hC0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hC1;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hC2;
  localparam logic [7:0] ADDR_IN_SERVICE = 8'hC3;

  // Field positions
  localparam int EN_GLOBAL_BIT = 7;
  localparam int EN2_TMR2_BIT = 0;
  localparam int EXT0_EDGE_BIT = 0;
  localparam int EXT1_EDGE_BIT = 1;
  localparam int ST_TAKEN_BIT = 0;
  localparam int ST_PREEMPT_BIT = 1;
  localparam int ST_RETURN_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
endpackage

// ### tb/flp_core_model.sv
// Purpose: Behavioural core that fetches offered vectors
// Assumes: Fetch comes a set number of cycles after the offer
// Notes: Fetching disabled leaves the offer standing for inspection
`timescale 1ns/1ps
module flp_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Vector link
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector,
  output logic core_vector_ack,
  // Bench control
  input wire logic ack_en,
  input wire logic [1:0] ack_lat,
  output logic [7:0] last_vec,
  output logic [7:0] acks
);
  logic [1:0] cnt;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_vector_ack <= 1'b0;
      last_vec <= 8'h00;
      acks <= 8'h00;
      cnt <= 2'h0;
    end else if (core_vector_ack) begin
      core_vector_ack <= 1'b0;
      cnt <= 2'h0;
    end else if (core_irq_req && ack_en) begin
      if (cnt == ack_lat) begin
        core_vector_ack <= 1'b1;
        last_vec <= core_vector;
        acks <= acks + 8'h01;
      end else begin
        cnt <= cnt + 2'h1;
      end
    end else begin
      cnt <= 2'h0;
    end
  end
endmodule

// ### tb/flp_irq_priority_chk.sv
// Purpose: Port-level assertions for the priority block
// Assumes: One clock, synchronous reset
// Notes: Helpers shadow only the enable and priority-high writes
`timescale 1ns/1ps
module flp_chk (
  // Watched ports
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer0_flag_clear,
  input wire logic timer1_flag_clear,
  input wire logic core_irq_req,
  input wire logic [7:0] core_vector,
  input wire logic core_vector_ack,
  input wire logic irq_out
);
  logic gen_reg, gen_next, tk;
  logic [7:0] hi_reg, hi_next;
  assign tk = core_vector_ack && core_irq_req;
  always_comb begin
    gen_next = gen_reg;
    hi_next = hi_reg;
    if (reg_wr && reg_addr == 8'hA8) gen_next = reg_wdata[7];
    if (reg_wr && reg_addr == 8'hB7) hi_next = reg_wdata;
  end
  always_ff @(posedge ref_clk) begin
    gen_reg <= sys_rst ? 1'b0 : gen_next;
    hi_reg <= sys_rst ? 8'h00 : hi_next;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_drop; tk |=> !core_irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("offer held after fetch");
  property p_tmr0_cause; tk && core_vector == 8'h0B |=> timer0_flag_clear; endproperty
  a_tmr0_cause: assert property (p_tmr0_cause) else $error("timer 0 flag not cleared");
  property p_tmr0_only;
    timer0_flag_clear |-> $past(tk) && $past(core_vector) == 8'h0B;
  endproperty
  a_tmr0_only: assert property (p_tmr0_only) else $error("stray timer 0 clear");
  property p_tmr1_cause; tk && core_vector == 8'h1B |=> timer1_flag_clear; endproperty
  a_tmr1_cause: assert property (p_tmr1_cause) else $error("timer 1 flag not cleared");
  property p_no_clr;
    tk && !(core_vector inside {8'h0B, 8'h1B}) |=> !timer0_flag_clear && !timer1_flag_clear;
  endproperty
  a_no_clr: assert property (p_no_clr) else $error("timer flag cleared by other source");
  property p_vec_legal;
    core_irq_req |-> core_vector inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B};
  endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("vector outside table");
  property p_gen_off; !gen_reg && !$past(gen_reg) |-> !core_irq_req; endproperty
  a_gen_off: assert property (p_gen_off) else $error("offer with global enable low");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_hi; reg_rd && reg_addr == 8'hB7 |=> reg_rdata == hi_reg; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("priority high readback");
  c_preempt: cover property (tk && core_vector == 8'h23);
  c_tmr0_clear: cover property (timer0_flag_clear);
  c_irq: cover property ($rose(irq_out));
endmodule
bind flp_irq_priority flp_chk flp_chk_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .timer0_flag_clear, .timer1_flag_clear, .core_irq_req,
  .core_vector, .core_vector_ack, .irq_out);

// ### tb/four_level_irq_priority_tb.sv
// Purpose: Self-checking bench for the priority block
// Assumes: Peripheral flags are held levels; timer flags drop on their clear pulse
// Notes: Waits settle 6 cycles to cover the pin synchroniser
`timescale 1ns/1ps
module four_level_irq_priority_tb;
  import flp_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, core_vector, last_vec, acks;
  logic ext_irq_0_n = 1'b1, ext_irq_1_n = 1'b1, timer0_overflow_flag = 1'b0;
  logic timer1_overflow_flag = 1'b0, timer2_overflow_flag = 1'b0, timer2_external_flag = 1'b0;
  logic receive_done_flag = 1'b0, transmit_done_flag = 1'b0, two_wire_serial_src = 1'b0;
  logic counter_overflow_flag = 1'b0, core_return = 1'b0, ack_en = 1'b0;
  logic [4:0] module_match_flags = 5'h00;
  logic [1:0] ack_lat = 2'h0;
  logic timer0_flag_clear, timer1_flag_clear, core_irq_req, core_vector_ack, irq_out;
  int errors = 0;
  int compares = 0;
  flp_irq_priority flp_irq_priority_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ext_irq_0_n, .ext_irq_1_n, .timer0_overflow_flag,
    .timer1_overflow_flag, .timer2_overflow_flag, .timer2_external_flag, .receive_done_flag,
    .transmit_done_flag, .two_wire_serial_src, .counter_overflow_flag, .module_match_flags,
    .timer0_flag_clear, .timer1_flag_clear, .core_irq_req, .core_vector, .core_vector_ack,
    .core_return, .irq_out);
  flp_core_model flp_core_model_inst (.ref_clk, .sys_rst, .core_irq_req, .core_vector,
    .core_vector_ack, .ack_en, .ack_lat, .last_vec, .acks);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (timer0_flag_clear) timer0_overflow_flag <= 1'b0;
    if (timer1_flag_clear) timer1_overflow_flag <= 1'b0;
  end
  task automatic tally_and_finish;
    $display("counts compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task automatic ret;
    @(posedge ref_clk);
    core_return <= 1'b1;
    @(posedge ref_clk);
    core_return <= 1'b0;
  endtask
  task automatic wait_ack(input string n, input logic [7:0] e);
    logic [7:0] c0;
    c0 = acks;
    for (int i = 0; i < 30 && acks == c0; i++) @(posedge ref_clk);
    if (acks == c0) begin
      errors++;
      $display("wrong value %s expected fetch seen none", n);
      tally_and_finish();
    end else begin
      chk(n, e, last_vec);
      cyc(2);
    end
  endtask
  // Multi-flag sources raise one of their flags at random
  task automatic set_src(input logic [7:0] s);
    logic [7:0] r;
    @(posedge ref_clk);
    r = 8'($urandom);
    ext_irq_0_n <= !s[0];
    timer0_overflow_flag <= s[1];
    ext_irq_1_n <= !s[2];
    timer1_overflow_flag <= s[3];
    receive_done_flag <= s[4] && r[0];
    transmit_done_flag <= s[4] && !r[0];
    two_wire_serial_src <= s[5];
    counter_overflow_flag <= s[6] && r[1];
    module_match_flags <= (s[6] && !r[1]) ? 5'h01 << (r[4:2] % 3'd5) : 5'h00;
    timer2_overflow_flag <= s[7] && r[5];
    timer2_external_flag <= s[7] && !r[5];
  endtask
  function automatic logic [7:0] exp_vec(input logic [7:0] s, h, l);
    int ord [8] = '{0, 5, 1, 2, 3, 4, 7, 6};
    logic [7:0] vt [8] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B};
    logic [7:0] v = 8'h00;
    int bl = -1;
    foreach (ord[k]) begin
      if (s[ord[k]] && int'({h[ord[k]], l[ord[k]]}) > bl) begin
        bl = int'({h[ord[k]], l[ord[k]]});
        v = vt[ord[k]];
      end
    end
    return v;
  endfunction
  initial begin
    logic [7:0] s, h, l;
    void'($urandom(32'hDA119C17));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd("prio_high_rst", ADDR_PRIO_HIGH, 8'h00);
    rd("unmapped", 8'h55, 8'h00);
    wr(ADDR_PRIO_HIGH, 8'hA5);
    rd("prio_high_rw", ADDR_PRIO_HIGH, 8'hA5);
    wr(ADDR_ENABLE, 8'h7F);
    wr(ADDR_ENABLE_2, 8'h01);
    set_src(8'hFF);
    cyc(6);
    chk("req_ea_off", 8'h00, {7'h00, core_irq_req});
    set_src(8'h00);
    wr(ADDR_ENABLE, 8'hFF);
    $display("test registers done");
    // First cases pin the tie order; the rest are random
    for (int i = 0; i < 40; i++) begin
      s = 8'($urandom);
      h = 8'($urandom);
      l = 8'($urandom);
      if (i < 3) {s, h, l} = i == 0 ? 24'hFF0000 : (i == 1 ? 24'hFFFFFF : 24'hDE0000);
      if (s == 8'h00) s = 8'h80;
      wr(ADDR_PRIO_HIGH, h);
      wr(ADDR_PRIO_LOW, l);
      set_src(s);
      cyc(6);
      chk("vector", exp_vec(s, h, l), core_vector);
      chk("req", 8'h01, {7'h00, core_irq_req});
      set_src(8'h00);
      cyc(6);
      chk("req_idle", 8'h00, {7'h00, core_irq_req});
    end
    $display("test arbitration done");
    wr(ADDR_PRIO_HIGH, 8'h30);
    wr(ADDR_PRIO_LOW, 8'h28);
    wr(ADDR_EXT_MODE, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h07);
    ack_lat <= 2'($urandom);
    ack_en <= 1'b1;
    set_src(8'h08);
    wait_ack("t1_vector", 8'h1B);
    rd("busy_l1", ADDR_IN_SERVICE, 8'h02);
    chk("t1_flag", 8'h00, {7'h00, timer1_overflow_flag});
    @(posedge ref_clk);
    receive_done_flag <= 1'b1;
    wait_ack("preempt_vector", 8'h23);
    rd("busy_l12", ADDR_IN_SERVICE, 8'h06);
    @(posedge ref_clk);
    ext_irq_0_n <= 1'b0;
    cyc(8);
    chk("low_waits", 8'h00, {7'h00, core_irq_req});
    @(posedge ref_clk);
    ext_irq_0_n <= 1'b1;
    receive_done_flag <= 1'b0;
    ret();
    rd("resume_l1", ADDR_IN_SERVICE, 8'h02);
    chk("still_waits", 8'h00, {7'h00, core_irq_req});
    ret();
    wait_ack("ext0_vector", 8'h03);
    rd("busy_l0", ADDR_IN_SERVICE, 8'h01);
    ret();
    cyc(4);
    chk("ext0_cleared", 8'h00, {7'h00, core_irq_req});
    set_src(8'h02);
    wait_ack("t0_vector", 8'h0B);
    chk("t0_flag", 8'h00, {7'h00, timer0_overflow_flag});
    ret();
    $display("test nesting done");
    rd("status", ADDR_IRQ_STAT, 8'h07);
    chk("irq_on", 8'h01, {7'h00, irq_out});
    wr(ADDR_IRQ_MASK, 8'h00);
    cyc(1);
    chk("irq_masked", 8'h00, {7'h00, irq_out});
    wr(ADDR_IRQ_MASK, 8'h07);
    wr(ADDR_IRQ_STAT, 8'h07);
    cyc(1);
    chk("irq_cleared", 8'h00, {7'h00, irq_out});
    $display("test events done");
    tally_and_finish();
  end
endmodule
